// ==== src/predriver_ctrl.sv ====
// six-channel predriver control, serial link and fault reporting
`timescale 1ns/1ps
module predriver_ctrl
  import predriver_pkg::*;
#(
  parameter bit PULSE_MODE = 1'b0
)(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        sclk_in,
  input  wire logic        cs_n_in,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe_out,
  input  wire logic [5:0]  parallel_channel_in,
  input  wire logic [5:0]  drain_sense_in,
  input  wire logic [5:0]  drain_sense_ext_in,
  input  wire logic        ext_reference_select_in,
  input  wire logic        batt_over_in,
  input  wire logic        batt_under_in,
  output logic [5:0]       gate_drive_out,
  output logic             fault_flag_n_out,
  output logic             fault_flag_n_oe_out
);

  // link clock domain: shift register and bit counter
  logic [7:0]       sr;
  logic [7:0]       next_sr;
  logic [CNT_W-1:0] bit_cnt;
  logic [CNT_W-1:0] next_bit_cnt;

  always_comb
  begin
    next_sr = {sr[6:0], serial_in};
    next_bit_cnt = bit_cnt;
    if (bit_cnt < OWN_BITS)
    begin
      next_bit_cnt = bit_cnt + 4'h1;
    end
  end

  always_ff @(posedge sclk_in)
  begin
    sr <= next_sr;
  end

  // counter ends with the frame's own chip select
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      bit_cnt <= 4'h0;
    end
    else
    begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // own fault bits first, then the bits received eight edges ago
  logic [7:0] snapshot;
  always_comb
  begin
    if (bit_cnt < OWN_BITS)
    begin
      serial_out = snapshot[3'h7 - bit_cnt[2:0]];
    end
    else
    begin
      serial_out = sr[7];
    end
  end

  // synchronisers for pins into the device clock
  localparam int unsigned SYNC_W = 22;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic [SYNC_W-1:0] pins;
  assign pins = {cs_n_in, ext_reference_select_in, batt_over_in,
                 batt_under_in, parallel_channel_in, drain_sense_in,
                 drain_sense_ext_in};

  always_ff @(posedge clk_in)
  begin
    sync_a <= pins;
    sync_b <= sync_a;
  end

  logic       cs_sync;
  logic       ref_ext;
  logic       over_v;
  logic       under_v;
  logic [5:0] par_req;
  logic [5:0] cmp_int;
  logic [5:0] cmp_ext;
  assign {cs_sync, ref_ext, over_v, under_v, par_req, cmp_int, cmp_ext}
    = sync_b;

  logic [5:0] cmp;
  assign cmp = ref_ext ? cmp_ext : cmp_int;

  logic batt_fault;
  assign batt_fault = over_v | under_v;

  // frame tracking from the synchronised chip select
  link_state_t state;
  link_state_t next_state;
  logic        cs_fall;
  logic        cs_rise;

  always_comb
  begin
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    next_state = state;
    case (state)
      LINK_IDLE:
      begin
        if (!cs_sync)
        begin
          cs_fall = 1'b1;
          next_state = LINK_FRAME;
        end
      end
      LINK_FRAME:
      begin
        if (cs_sync)
        begin
          cs_rise = 1'b1;
          next_state = LINK_IDLE;
        end
      end
      default:
      begin
        next_state = LINK_IDLE;
      end
    endcase
  end

  // control register and fault snapshot
  logic [5:0] ctrl;
  logic [5:0] next_ctrl;
  logic [7:0] next_snapshot;
  logic [7:0] live_word;
  logic [5:0] ch_fault;
  logic       next_oe;

  always_comb
  begin
    next_ctrl = ctrl;
    next_snapshot = snapshot;
    next_oe = serial_out_oe_out;
    if (cs_rise)
    begin
      next_ctrl = sr[5:0];
      next_snapshot = FAULT_RESET;
      next_oe = 1'b0;
    end
    else if (cs_fall)
    begin
      next_snapshot = live_word;
      next_oe = 1'b1;
    end
    else if (state == LINK_IDLE)
    begin
      next_snapshot = live_word;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= LINK_IDLE;
      ctrl <= CTRL_RESET;
      snapshot <= FAULT_RESET;
      serial_out_oe_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ctrl <= next_ctrl;
      snapshot <= next_snapshot;
      serial_out_oe_out <= next_oe;
    end
  end

  // shared pulse timebase for the pulsing variant
  logic [PULSE_W-1:0] pulse_cnt;
  logic [PULSE_W-1:0] next_pulse_cnt;
  logic               pulse_on;

  always_comb
  begin
    if (pulse_cnt == PULSE_W'(PULSE_PERIOD_CYCLES - 1))
    begin
      next_pulse_cnt = '0;
    end
    else
    begin
      next_pulse_cnt = pulse_cnt + 1'b1;
    end
  end

  assign pulse_on = pulse_cnt < PULSE_W'(PULSE_ON_CYCLES);

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pulse_cnt <= '0;
    end
    else
    begin
      pulse_cnt <= next_pulse_cnt;
    end
  end

  // per-channel request, short deglitch and gate drive
  logic [5:0] req;
  logic [5:0] short_hold;
  logic [5:0] next_gate;
  logic [5:0] confirm;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++)
    begin : g_ch
      logic [DG_W-1:0] dg_cnt;
      logic [DG_W-1:0] next_dg_cnt;
      logic            next_hold;
      logic            raw_short;

      assign req[i] = ctrl[i] | par_req[i];
      assign raw_short = gate_drive_out[i] & cmp[i];
      assign confirm[i] = raw_short && !short_hold[i]
        && dg_cnt == DG_W'(SHORT_DEGLITCH_CYCLES - 1);

      always_comb
      begin
        next_dg_cnt = '0;
        next_hold = short_hold[i];
        if (raw_short && !short_hold[i])
        begin
          next_dg_cnt = dg_cnt + 1'b1;
          if (dg_cnt == DG_W'(SHORT_DEGLITCH_CYCLES - 1))
          begin
            next_hold = 1'b1;
            next_dg_cnt = '0;
          end
        end
        if (!req[i] || batt_fault)
        begin
          next_hold = 1'b0;
        end
        else if (PULSE_MODE && short_hold[i] && pulse_on
                 && gate_drive_out[i] && !cmp[i])
        begin
          next_hold = 1'b0;
        end
        next_gate[i] = req[i] && !batt_fault &&
          (!next_hold || (PULSE_MODE && pulse_on));
      end

      always_ff @(posedge clk_in)
      begin
        if (rst_in)
        begin
          dg_cnt <= '0;
          short_hold[i] <= 1'b0;
        end
        else
        begin
          dg_cnt <= next_dg_cnt;
          short_hold[i] <= next_hold;
        end
      end

      // short while held, open load when requested off
      assign ch_fault[i] = !batt_fault &&
        (short_hold[i] || (!req[i] && cmp[i]));

      a_deglitch_len: assert property (
        @(posedge clk_in) disable iff (rst_in)
        $rose(short_hold[i]) |->
          $past(dg_cnt) == DG_W'(SHORT_DEGLITCH_CYCLES - 1))
        else $error("short confirmed before deglitch interval");
    end
  endgenerate

  always_comb
  begin
    live_word = FAULT_RESET;
    live_word[BIT_OVER] = over_v;
    live_word[BIT_UNDER] = under_v;
    live_word[5:0] = ch_fault;
  end

  logic any_fault;
  logic next_flag_oe;
  assign any_fault = |live_word;
  assign next_flag_oe = any_fault;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      gate_drive_out <= CTRL_RESET;
      fault_flag_n_oe_out <= 1'b0;
    end
    else
    begin
      gate_drive_out <= next_gate;
      fault_flag_n_oe_out <= next_flag_oe;
    end
  end

  assign fault_flag_n_out = 1'b0;

  // checks
  sequence s_cs_fall;
    (state == LINK_IDLE) && !cs_sync;
  endsequence

  sequence s_cs_rise;
    (state == LINK_FRAME) && cs_sync;
  endsequence

  a_batt_gates_off: assert property (
    @(posedge clk_in) disable iff (rst_in)
    batt_fault |=> gate_drive_out == 6'h00)
    else $error("gate driven during battery fault");

  a_snapshot_load: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_cs_fall |=> snapshot == $past(live_word) && serial_out_oe_out)
    else $error("fault word not captured at frame start");

  a_snapshot_frozen: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state == LINK_FRAME) && !cs_sync |=> $stable(snapshot))
    else $error("fault word changed inside frame");

  a_frame_end: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_cs_rise |=> !serial_out_oe_out && snapshot == FAULT_RESET
      && ctrl == $past(sr[5:0]))
    else $error("frame end did not latch and float");

  a_ctrl_steady: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !cs_rise |=> $stable(ctrl))
    else $error("control changed outside frame end");

  a_flag_tracks: assert property (
    @(posedge clk_in) disable iff (rst_in)
    any_fault |=> fault_flag_n_oe_out)
    else $error("fault flag not asserted");

  a_batt_masks: assert property (
    @(posedge clk_in) disable iff (rst_in)
    batt_fault |-> live_word[5:0] == 6'h00 && any_fault)
    else $error("channel fault reported during battery fault");

  a_request_or: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !batt_fault && (req & ~short_hold & ~confirm) == req
      |=> gate_drive_out == $past(req))
    else $error("gate does not follow request");

  a_shutdown_off: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !PULSE_MODE && $rose(short_hold[0]) |-> !gate_drive_out[0])
    else $error("gate left on after confirmed short");

  a_count_sat: assert property (
    @(posedge sclk_in) disable iff (cs_n_in)
    bit_cnt <= OWN_BITS)
    else $error("bit counter ran past own bits");

endmodule

// ==== src/predriver_pkg.sv ====
// constants and types shared by the six-channel predriver control
package predriver_pkg;
  localparam int unsigned NUM_CH           = 6;
  localparam int unsigned WORD_BITS        = 8;
  localparam int unsigned CNT_W            = 4;
  localparam int unsigned BIT_OVER         = 7;
  localparam int unsigned BIT_UNDER        = 6;
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned SHORT_DEGLITCH_NS = 10000;
  localparam int unsigned PULSE_PERIOD_NS  = 32000;
  localparam int unsigned PULSE_ON_NS      = 3200;
  localparam int unsigned SHORT_DEGLITCH_CYCLES =
    (SHORT_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_PERIOD_CYCLES =
    (PULSE_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int unsigned PULSE_ON_CYCLES  =
    (PULSE_ON_NS * CLK_MHZ) / 1000;
  localparam int unsigned DG_W             = 11;
  localparam int unsigned PULSE_W          = 12;
  localparam logic [5:0]  CTRL_RESET       = 6'h00;
  localparam logic [7:0]  FAULT_RESET      = 8'h00;
  localparam logic [3:0]  OWN_BITS         = 4'h8;
  typedef enum logic {LINK_IDLE, LINK_FRAME} link_state_t;
endpackage

// ==== test/serial_host_model.sv ====
// host side model that runs the serial link in frames
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic so_in,
  input  wire logic so_oe_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out
);
  initial
  begin
    sclk_out = 1'h0;
    cs_n_out = 1'h1;
    sdi_out  = 1'h0;
  end

  // one frame of n bits, msb first; bits above n come back zero, bits sampled while the output is off come back unknown
  task automatic xfer(input int n, input logic [15:0] d,
                      output logic [15:0] q);
    q = '0;
    cs_n_out = 1'h0;
    #60;
    for (int i = n - 1; i >= 0; i--)
    begin
      q[i] = so_oe_in ? so_in : 1'hx;
      sdi_out = d[i];
      #7.5 sclk_out = 1'h1;
      #7.5 sclk_out = 1'h0;
    end
    #20 cs_n_out = 1'h1;
    sdi_out = 1'h0;
    #60;
  endtask
endmodule

// ==== test/test_six_channel_predriver_control.sv ====
// self-checking bench for the predriver control
`timescale 1ns/1ps
module test_six_channel_predriver_control;
  import predriver_pkg::*;
  logic        clk_in;
  logic        rst_in;
  logic        sclk_in;
  logic        cs_n_in;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe_out;
  logic [5:0]  parallel_channel_in;
  logic [5:0]  drain_sense_in;
  logic [5:0]  drain_sense_ext_in;
  logic        ext_reference_select_in;
  logic        batt_over_in;
  logic        batt_under_in;
  logic [5:0]  gate_drive_out;
  logic [5:0]  gate_p;
  logic        fault_flag_n_out;
  logic        fault_flag_n_oe_out;
  wire         flt_n;
  logic [15:0] q;
  int          n_fail;
  int          checks;
  int          cyc;
  int          ones;

  // open-drain fault line with pull-up
  assign flt_n = (fault_flag_n_oe_out && fault_flag_n_out === 1'h0) ? 1'h0
                                                                   : 1'h1;

  predriver_ctrl #(.PULSE_MODE(1'h0)) uut (
    .clk_in, .rst_in, .sclk_in, .cs_n_in, .serial_in, .serial_out,
    .serial_out_oe_out, .parallel_channel_in, .drain_sense_in,
    .drain_sense_ext_in, .ext_reference_select_in, .batt_over_in,
    .batt_under_in, .gate_drive_out, .fault_flag_n_out,
    .fault_flag_n_oe_out
  );

  predriver_ctrl #(.PULSE_MODE(1'h1)) uut_pulse (
    .clk_in, .rst_in, .sclk_in, .cs_n_in, .serial_in, .serial_out(),
    .serial_out_oe_out(), .parallel_channel_in, .drain_sense_in,
    .drain_sense_ext_in, .ext_reference_select_in, .batt_over_in,
    .batt_under_in, .gate_drive_out(gate_p), .fault_flag_n_out(),
    .fault_flag_n_oe_out()
  );

  serial_host_model host (
    .so_in(serial_out), .so_oe_in(serial_out_oe_out),
    .sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdi_out(serial_in)
  );

  initial
  begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp, input string m);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic frame(input int n, input logic [15:0] d);
    host.xfer(n, d, q);
    tick(1);
  endtask

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      $display("ERROR %0t: timeout", $time);
      final_report();
    end
  end

  initial
  begin
    rst_in = 1'h1;
    parallel_channel_in = 6'h00;
    drain_sense_in = 6'h00;
    drain_sense_ext_in = 6'h00;
    ext_reference_select_in = 1'h0;
    batt_over_in = 1'h0;
    batt_under_in = 1'h0;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    tick(4);
    rst_in = 1'h0;
    tick(4);
    chk({gate_drive_out, serial_out_oe_out, flt_n}, 8'h01, "reset");
    frame(8, 16'h00a5);
    chk(q[7:0], 8'h00, "idle word");
    chk({gate_drive_out, serial_out_oe_out}, 7'h4a, "serial on");
    parallel_channel_in = 6'h12;
    tick(5);
    chk(gate_drive_out, 6'h37, "or of paths");
    parallel_channel_in = 6'h00;
    drain_sense_in = 6'h08;
    tick(5);
    chk(flt_n, 1'h0, "open load flag");
    fork
      frame(8, 16'h0025);
      begin
        tick(6);
        drain_sense_in = 6'h0a;
      end
    join
    chk(q[7:0], 8'h08, "frozen capture");
    frame(8, 16'h0025);
    chk(q[7:0], 8'h0a, "rearmed");
    ext_reference_select_in = 1'h1;
    tick(5);
    chk(flt_n, 1'h1, "ext ref quiet");
    drain_sense_ext_in = 6'h10;
    tick(5);
    frame(8, 16'h0025);
    chk(q[7:0], 8'h10, "ext ref fault");
    ext_reference_select_in = 1'h0;
    drain_sense_ext_in = 6'h00;
    drain_sense_in = 6'h01;
    tick(1200);
    chk({gate_drive_out, flt_n}, 7'h4b, "deglitch");
    tick(100);
    chk({gate_drive_out, flt_n}, 7'h48, "short off");
    ones = 0;
    repeat (4000)
    begin
      tick(1);
      ones += gate_p[0];
    end
    chk(ones > 300 && ones < 500, 1'h1, "pulse duty");
    frame(8, 16'h0025);
    chk(q[7:0], 8'h01, "short bit");
    batt_over_in = 1'h1;
    tick(5);
    chk({gate_drive_out, flt_n}, 7'h00, "over off");
    frame(8, 16'h0025);
    chk(q[7:0], 8'h80, "over word");
    batt_over_in = 1'h0;
    batt_under_in = 1'h1;
    tick(5);
    frame(8, 16'h0025);
    chk(q[7:0], 8'h40, "under word");
    batt_under_in = 1'h0;
    drain_sense_in = 6'h00;
    tick(5);
    chk(gate_drive_out, 6'h25, "resume");
    frame(16, 16'ha53c);
    chk(q, 16'h00a5, "chain");
    chk(gate_drive_out, 6'h3c, "last six");
    final_report();
  end
endmodule
